// *** core/bbt_pkg.sv ***
/*
 * Constants, register map and mode types of the bus break comparator
 * with branch trace. Assumes a 32-bit APB slave with a byte address.
 */

//**********************************************************************
// Overview
//**********************************************************************
// Overview of operation
// - Address ignore: every address matches
// - Normal mode compares address on bus cycles
// - Before mode breaks before fetched instruction runs
// - After mode breaks after fetched instruction ran
// - Address mask bits set match anything
// - Prefetch modes use only address and count
// - Data ignore: value and size irrelevant
// - Data compared and qualified by access size
// - Data mask bits set match anything
// - CPU, DTC, DMA cycles each qualify independently
// - Direction: read, write or both
// - Break after programmed count, max 65535, default 1
// - Count ignore: break on first match
// - Small variant keeps four branch sources
// - Large variant keeps eight source/destination entries
// - Entry holds type tag and address
// - Index zero is the newest entry
package bbt_pkg;

    //******************************************************************
    // Register offsets
    //******************************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ADDR = 8'h04;
    localparam logic [7:0] OFS_AMASK = 8'h08;
    localparam logic [7:0] OFS_DATA = 8'h0C;
    localparam logic [7:0] OFS_DMASK = 8'h10;
    localparam logic [7:0] OFS_COUNT = 8'h14;
    localparam logic [7:0] OFS_MCOUNT = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_CLEAR = 8'h20;
    localparam logic [7:0] OFS_IRQEN = 8'h24;
    localparam logic [7:0] OFS_TIDX = 8'h28;
    localparam logic [7:0] OFS_TDATA = 8'h2C;
    localparam logic [7:0] OFS_TINFO = 8'h30;

    //******************************************************************
    // Control fields
    //******************************************************************
    localparam int CTL_EN = 0;
    localparam int CTL_AMODE = 1;
    localparam int CTL_AMASK_EN = 3;
    localparam int CTL_DIGN = 4;
    localparam int CTL_DMASK_EN = 5;
    localparam int CTL_SIZE = 6;
    localparam int CTL_ST_CPU = 8;
    localparam int CTL_ST_DTC = 9;
    localparam int CTL_ST_DMA = 10;
    localparam int CTL_DIR = 11;
    localparam int CTL_CIGN = 13;
    localparam int CTL_W = 14;
    localparam logic [31:0] CTRL_RST = 32'h0000_2710;
    localparam logic [15:0] COUNT_RST = 16'h0001;

    //******************************************************************
    // Status and interrupt bits
    //******************************************************************
    localparam int ST_BREAK = 0;
    localparam int ST_TWRAP = 1;
    localparam int ST_W = 2;
    localparam int TYPE_BIT = 31;

    //******************************************************************
    // Modes
    //******************************************************************
    typedef enum logic [1:0] {
        AM_IGNORE = 2'b00,
        AM_NORMAL = 2'b01,
        AM_PF_BEFORE = 2'b10,
        AM_PF_AFTER = 2'b11
    } bbt_amode_e;

    typedef enum logic [1:0] {
        SZ_BYTE = 2'b00,
        SZ_WORD = 2'b01,
        SZ_LONG = 2'b10
    } bbt_size_e;

    typedef enum logic [1:0] {
        DIR_BOTH = 2'b00,
        DIR_READ = 2'b01,
        DIR_WRITE = 2'b10
    } bbt_dir_e;

    typedef enum logic [1:0] {
        MST_CPU = 2'b00,
        MST_DTC = 2'b01,
        MST_DMA = 2'b10
    } bbt_master_e;

endpackage

// *** core/bbt_core.sv ***
/*
 * Bus break comparator and branch trace recorder, APB register slave.
 * Assumes the observed bus presents one-cycle pulses synchronous to
 * pclk, and the core reports instruction start and end by address.
 */
// Implementation choices: register access over APB and the address map.
`timescale 1ns/10ps

module bbt_core #(
    parameter int ADDR_W = 24,
    parameter int DATA_W = 32,
    parameter int CNT_W = 16,
    parameter bit TRACE_LARGE = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic bus_valid,
    input wire logic [ADDR_W-1:0] bus_addr,
    input wire logic [DATA_W-1:0] bus_data,
    input wire logic [1:0] bus_size,
    input wire logic bus_write,
    input wire logic [1:0] bus_master,
    input wire logic bus_fetch,
    input wire logic insn_start,
    input wire logic insn_done,
    input wire logic [ADDR_W-1:0] insn_addr,
    input wire logic br_valid,
    input wire logic [ADDR_W-1:0] br_src,
    input wire logic [ADDR_W-1:0] br_dst,
    output logic break_req,
    output logic irq
);

    //******************************************************************
    // Trace geometry
    //******************************************************************
    localparam int DEPTH = TRACE_LARGE ? 8 : 4;
    localparam int STEP = TRACE_LARGE ? 2 : 1;
    localparam int IDX_W = $clog2(DEPTH);
    localparam int FILL_W = IDX_W + 1;
    localparam int ENT_W = ADDR_W + 1;

    //******************************************************************
    // State
    //******************************************************************
    logic [bbt_pkg::CTL_W-1:0] ctrl_q;
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] amask_q;
    logic [DATA_W-1:0] data_q;
    logic [DATA_W-1:0] dmask_q;
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] mcount_q;
    logic [CNT_W-1:0] mcount_d;
    logic [bbt_pkg::ST_W-1:0] status_q;
    logic [bbt_pkg::ST_W-1:0] status_d;
    logic [bbt_pkg::ST_W-1:0] irqen_q;
    logic [IDX_W-1:0] tidx_q;
    logic [FILL_W-1:0] fill_q;
    logic [FILL_W-1:0] fill_d;
    logic fetch_pend_q;
    logic fetch_pend_d;
    logic [ENT_W-1:0] ent_q [DEPTH];
    logic [ENT_W-1:0] new_ent [2];
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic break_q;
    logic irq_q;

    //******************************************************************
    // Control field views
    //******************************************************************
    wire logic ctl_en = ctrl_q[bbt_pkg::CTL_EN];
    wire bbt_pkg::bbt_amode_e amode =
        bbt_pkg::bbt_amode_e'(ctrl_q[bbt_pkg::CTL_AMODE +: 2]);
    wire logic amask_en = ctrl_q[bbt_pkg::CTL_AMASK_EN];
    wire logic data_ign = ctrl_q[bbt_pkg::CTL_DIGN];
    wire logic dmask_en = ctrl_q[bbt_pkg::CTL_DMASK_EN];
    wire bbt_pkg::bbt_size_e dsize =
        bbt_pkg::bbt_size_e'(ctrl_q[bbt_pkg::CTL_SIZE +: 2]);
    wire bbt_pkg::bbt_dir_e dir =
        bbt_pkg::bbt_dir_e'(ctrl_q[bbt_pkg::CTL_DIR +: 2]);
    wire logic cnt_ign = ctrl_q[bbt_pkg::CTL_CIGN];

    //******************************************************************
    // Address comparison
    //******************************************************************
    wire logic [ADDR_W-1:0] a_care = amask_en ? ~amask_q : '1;
    wire logic bus_a_hit =
        ((bus_addr ^ addr_q) & a_care) == '0;
    wire logic insn_a_hit =
        ((insn_addr ^ addr_q) & a_care) == '0;
    wire logic pf_mode = amode == bbt_pkg::AM_PF_BEFORE ||
        amode == bbt_pkg::AM_PF_AFTER;

    //******************************************************************
    // Data comparison
    //******************************************************************
    // Narrow accesses are assumed to sit in the low data lanes
    logic [DATA_W-1:0] size_care;
    always_comb begin
        size_care = '1;
        unique case (dsize)
            bbt_pkg::SZ_BYTE: size_care = DATA_W'(32'h0000_00FF);
            bbt_pkg::SZ_WORD: size_care = DATA_W'(32'h0000_FFFF);
            default: size_care = '1;
        endcase
    end
    wire logic [DATA_W-1:0] d_care =
        size_care & (dmask_en ? ~dmask_q : '1);
    wire logic d_hit = data_ign ||
        ((((bus_data ^ data_q) & d_care) == '0) &&
        bus_size == dsize);

    //******************************************************************
    // Bus state and direction
    //******************************************************************
    wire logic st_hit =
        (bus_master == bbt_pkg::MST_CPU &&
         ctrl_q[bbt_pkg::CTL_ST_CPU]) ||
        (bus_master == bbt_pkg::MST_DTC &&
         ctrl_q[bbt_pkg::CTL_ST_DTC]) ||
        (bus_master == bbt_pkg::MST_DMA &&
         ctrl_q[bbt_pkg::CTL_ST_DMA]);
    wire logic dir_hit = dir == bbt_pkg::DIR_BOTH ||
        (dir == bbt_pkg::DIR_READ && !bus_write) ||
        (dir == bbt_pkg::DIR_WRITE && bus_write);

    //******************************************************************
    // Combined condition
    //******************************************************************
    // Data, state and direction only in address-ignore or normal mode
    wire logic bus_hit = bus_valid && !pf_mode &&
        (amode == bbt_pkg::AM_IGNORE || bus_a_hit) &&
        d_hit && st_hit && dir_hit;
    // Fetch tag: only an opcode fetch of the address arms it
    wire logic fetch_hit = bus_valid && bus_fetch && pf_mode &&
        bus_a_hit;
    wire logic pf_hit = fetch_pend_q && insn_a_hit &&
        ((amode == bbt_pkg::AM_PF_BEFORE && insn_start) ||
         (amode == bbt_pkg::AM_PF_AFTER && insn_done));
    wire logic cond_hit = ctl_en && (bus_hit || pf_hit);

    //******************************************************************
    // Match counter
    //******************************************************************
    // A count of zero is treated as one so the break cannot go dead
    wire logic [CNT_W-1:0] mcount_inc = mcount_q + CNT_W'(1);
    wire logic count_done = cnt_ign ||
        mcount_inc >= count_q;
    wire logic fire = cond_hit && count_done;
    assign mcount_d = !cond_hit ? mcount_q :
        (count_done ? '0 : mcount_inc);
    assign fetch_pend_d = !pf_mode ? 1'b0 :
        (fetch_hit ? 1'b1 : (pf_hit ? 1'b0 : fetch_pend_q));

    //******************************************************************
    // APB decode
    //******************************************************************
    wire logic apb_acc = psel && penable && !pready_q;
    wire logic apb_done = psel && penable && pready_q;
    wire logic wr = apb_done && pwrite;
    wire logic wr_ctrl = wr && paddr == bbt_pkg::OFS_CTRL;
    wire logic wr_addr = wr && paddr == bbt_pkg::OFS_ADDR;
    wire logic wr_amask = wr && paddr == bbt_pkg::OFS_AMASK;
    wire logic wr_data = wr && paddr == bbt_pkg::OFS_DATA;
    wire logic wr_dmask = wr && paddr == bbt_pkg::OFS_DMASK;
    wire logic wr_count = wr && paddr == bbt_pkg::OFS_COUNT;
    wire logic wr_mcount = wr && paddr == bbt_pkg::OFS_MCOUNT;
    wire logic wr_clear = wr && paddr == bbt_pkg::OFS_CLEAR;
    wire logic wr_irqen = wr && paddr == bbt_pkg::OFS_IRQEN;
    wire logic wr_tidx = wr && paddr == bbt_pkg::OFS_TIDX;
    wire logic wr_tinfo = wr && paddr == bbt_pkg::OFS_TINFO;
    wire logic [ENT_W-1:0] t_sel = ent_q[tidx_q];
    wire logic [31:0] t_word = {t_sel[ADDR_W],
        {(31-ADDR_W){1'b0}}, t_sel[ADDR_W-1:0]};
    wire logic mapped = paddr[1:0] == 2'b00 &&
        paddr <= bbt_pkg::OFS_TINFO;
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        unique case (paddr)
            bbt_pkg::OFS_CTRL: rd_mux = 32'(ctrl_q);
            bbt_pkg::OFS_ADDR: rd_mux = 32'(addr_q);
            bbt_pkg::OFS_AMASK: rd_mux = 32'(amask_q);
            bbt_pkg::OFS_DATA: rd_mux = 32'(data_q);
            bbt_pkg::OFS_DMASK: rd_mux = 32'(dmask_q);
            bbt_pkg::OFS_COUNT: rd_mux = 32'(count_q);
            bbt_pkg::OFS_MCOUNT: rd_mux = 32'(mcount_q);
            bbt_pkg::OFS_STATUS: rd_mux = 32'(status_q);
            bbt_pkg::OFS_IRQEN: rd_mux = 32'(irqen_q);
            bbt_pkg::OFS_TIDX: rd_mux = 32'(tidx_q);
            bbt_pkg::OFS_TDATA: rd_mux = t_word;
            bbt_pkg::OFS_TINFO: rd_mux = 32'(fill_q);
            default: rd_mux = '0;
        endcase
    end

    //******************************************************************
    // Status and interrupt
    //******************************************************************
    // Hardware set wins over a software clear in the same cycle
    wire logic [bbt_pkg::ST_W-1:0] st_set = {
        br_valid && fill_q == FILL_W'(DEPTH), fire};
    assign status_d = (status_q &
        ~(wr_clear ? pwdata[bbt_pkg::ST_W-1:0] : '0)) | st_set;

    //******************************************************************
    // Trace recorder
    //******************************************************************
    assign new_ent[0] = TRACE_LARGE ? {1'b1, br_dst}
        : {1'b0, br_src};
    assign new_ent[1] = {1'b0, br_src};
    wire logic [FILL_W-1:0] fill_base = wr_tinfo ? '0 : fill_q;
    assign fill_d = !br_valid ? fill_base :
        (fill_base >= FILL_W'(DEPTH - STEP) ? FILL_W'(DEPTH) :
         fill_base + FILL_W'(STEP));

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_ent
            logic [ENT_W-1:0] ent_d;
            if (gi < STEP) begin : g_head
                assign ent_d = new_ent[gi];
            end else begin : g_tail
                assign ent_d = ent_q[gi-STEP];
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ent_q[gi] <= '0;
                end else if (br_valid) begin
                    ent_q[gi] <= ent_d;
                end
            end
        end
    endgenerate

    //******************************************************************
    // Configuration registers
    //******************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= bbt_pkg::CTRL_RST[bbt_pkg::CTL_W-1:0];
            addr_q <= '0;
            amask_q <= '0;
            data_q <= '0;
            dmask_q <= '0;
            count_q <= bbt_pkg::COUNT_RST;
            irqen_q <= '0;
            tidx_q <= '0;
        end else begin
            if (wr_ctrl) ctrl_q <= pwdata[bbt_pkg::CTL_W-1:0];
            if (wr_addr) addr_q <= pwdata[ADDR_W-1:0];
            if (wr_amask) amask_q <= pwdata[ADDR_W-1:0];
            if (wr_data) data_q <= pwdata[DATA_W-1:0];
            if (wr_dmask) dmask_q <= pwdata[DATA_W-1:0];
            if (wr_count) count_q <= pwdata[CNT_W-1:0];
            if (wr_irqen) irqen_q <= pwdata[bbt_pkg::ST_W-1:0];
            if (wr_tidx) tidx_q <= pwdata[IDX_W-1:0];
        end
    end

    //******************************************************************
    // Comparator and status state
    //******************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mcount_q <= '0;
            fetch_pend_q <= 1'b0;
            status_q <= '0;
            fill_q <= '0;
            break_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            // A write to the MCOUNT offset restarts the running match count
            mcount_q <= wr_mcount ? '0 : mcount_d;
            fetch_pend_q <= fetch_pend_d;
            status_q <= status_d;
            fill_q <= fill_d;
            break_q <= fire;
            irq_q <= |(status_d & irqen_q);
        end
    end

    //******************************************************************
    // APB answer
    //******************************************************************
    // One wait state so read data and ready come from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= apb_acc;
            prdata_q <= (apb_acc && !pwrite) ? rd_mux : '0;
            pslverr_q <= apb_acc && !mapped;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign break_req = break_q;
    assign irq = irq_q;

endmodule // bbt_core

// *** verification/bbt_chk.sv ***
/* Port checker for bbt_core.
   Assumes it is bound onto every bbt_core instance. */
`timescale 1ns/10ps

module bbt_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic bus_valid,
    input wire logic insn_start,
    input wire logic insn_done,
    input wire logic br_valid,
    input wire logic break_req,
    input wire logic irq
);
    //********
    // Properties
    //********
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic bad_adr;
    assign bad_adr = paddr > 8'h30 || paddr[1:0] != 2'h0;
    chk_pready_due: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    chk_pready_once: assert property (pready |=> !pready)
        else $error("pready held too long");
    chk_err_bad: assert property (pready && bad_adr |-> pslverr)
        else $error("no error for unmapped address");
    chk_err_good: assert property (pready && !bad_adr |-> !pslverr)
        else $error("error for mapped address");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    chk_break_cause: assert property (
        break_req |-> $past(bus_valid || insn_start || insn_done))
        else $error("break without observed cycle");
    // Only a break, a trace overflow or a register write may raise it
    chk_irq_rise: assert property ($rose(irq) |-> break_req
        || $past(br_valid) || $past(pready && pwrite, 2))
        else $error("interrupt rose without cause");
    chk_irq_fall: assert property ($fell(irq) |->
        $past(pready && pwrite) || $past(pready && pwrite, 2))
        else $error("interrupt fell without register write");
    cov_break: cover property (break_req);
    cov_irq: cover property ($rose(irq));
    cov_err: cover property (pready && pslverr);
endmodule // bbt_chk

bind bbt_core bbt_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .bus_valid, .insn_start,
    .insn_done, .br_valid, .break_req, .irq);

// *** verification/bbt_bus_model.sv ***
/* Model of the processor and bus masters seen by the comparator.
   Assumes tasks are called by the bench just after a clock edge. */
`timescale 1ns/10ps

module bbt_bus_model (
    input wire logic pclk,
    output logic bus_valid,
    output logic [23:0] bus_addr,
    output logic [31:0] bus_data,
    output logic [1:0] bus_size,
    output logic bus_write,
    output logic [1:0] bus_master,
    output logic bus_fetch,
    output logic insn_start,
    output logic insn_done,
    output logic [23:0] insn_addr,
    output logic br_valid,
    output logic [23:0] br_src,
    output logic [23:0] br_dst
);
    initial begin
        {bus_valid, bus_addr, bus_data, bus_size, bus_write} = '0;
        {bus_master, bus_fetch, insn_start, insn_done, insn_addr} = '0;
        {br_valid, br_src, br_dst} = '0;
    end
    //********
    // Transfers
    //********
    // Idle lines carry the inverse so stale values never match
    task cyc(input logic [23:0] a, input logic [31:0] d,
        input logic [1:0] s, input logic w, input logic [1:0] m,
        input logic f);
        @(posedge pclk);
        {bus_valid, bus_addr, bus_data, bus_size} <= {1'b1, a, d, s};
        {bus_write, bus_master, bus_fetch} <= {w, m, f};
        @(posedge pclk);
        {bus_valid, bus_addr, bus_data, bus_size} <= {1'b0, ~a, ~d, ~s};
        {bus_write, bus_master, bus_fetch} <= {~w, ~m, ~f};
    endtask
    task ins(input logic st, input logic [23:0] a);
        @(posedge pclk);
        {insn_start, insn_done, insn_addr} <= {st, ~st, a};
        @(posedge pclk);
        {insn_start, insn_done, insn_addr} <= {2'h0, ~a};
    endtask
    task br(input logic [23:0] s, input logic [23:0] d);
        @(posedge pclk);
        {br_valid, br_src, br_dst} <= {1'b1, s, d};
        @(posedge pclk);
        {br_valid, br_src, br_dst} <= {1'b0, ~s, ~d};
    endtask
endmodule // bbt_bus_model

// *** verification/tb_top.sv ***
/* Self-checking bench for bbt_core with an APB master.
   Assumes bbt_bus_model drives the observed bus side. */
`timescale 1ns/10ps

module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, bus_data;
    logic bus_valid, bus_write, bus_fetch, insn_start, insn_done;
    logic br_valid, break_req, irq;
    logic [23:0] bus_addr, insn_addr, br_src, br_dst;
    logic [1:0] bus_size, bus_master;
    int n_errors = 0;
    int n_tests = 0;
    bbt_core i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .bus_valid, .bus_addr,
        .bus_data, .bus_size, .bus_write, .bus_master, .bus_fetch,
        .insn_start, .insn_done, .insn_addr, .br_valid, .br_src, .br_dst,
        .break_req, .irq);
    bbt_bus_model i_bus (.pclk, .bus_valid, .bus_addr, .bus_data,
        .bus_size, .bus_write, .bus_master, .bus_fetch, .insn_start,
        .insn_done, .insn_addr, .br_valid, .br_src, .br_dst);
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    //********
    // Helpers
    //********
    task give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task ck(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (n >= 40) begin
            n_errors++;
            give_verdict();
        end
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    function automatic logic [31:0] cf(input logic [1:0] am, input logic di,
        input logic ci, input logic [2:0] st, input logic [1:0] dr,
        input logic [1:0] sz, input logic mk);
        cf = 32'h0;
        cf[bbt_pkg::CTL_EN] = 1'b1;
        cf[bbt_pkg::CTL_AMODE +: 2] = am;
        {cf[bbt_pkg::CTL_AMASK_EN], cf[bbt_pkg::CTL_DMASK_EN]} = {mk, mk};
        {cf[bbt_pkg::CTL_DIGN], cf[bbt_pkg::CTL_CIGN]} = {di, ci};
        cf[bbt_pkg::CTL_SIZE +: 2] = sz;
        cf[bbt_pkg::CTL_ST_CPU +: 3] = st;
        cf[bbt_pkg::CTL_DIR +: 2] = dr;
    endfunction
    task chkbr(input logic e);
        @(posedge pclk);
        ck(32'(break_req), 32'(e));
    endtask
    task go(input logic [23:0] a, input logic [31:0] d, input logic [1:0] s,
        input logic w, input logic [1:0] m, input logic e);
        i_bus.cyc(a, d, s, w, m, 1'b0);
        chkbr(e);
    endtask
    task ctl(input logic [31:0] v);
        apb(1'b1, bbt_pkg::OFS_CTRL, v);
    endtask
    //********
    // Scenarios
    //********
    task t_regs;
        apb(1'b0, bbt_pkg::OFS_CTRL, 32'h0);
        ck(rd, 32'h0000_2710);
        apb(1'b0, bbt_pkg::OFS_COUNT, 32'h0);
        ck(rd, 32'h1);
        apb(1'b0, 8'h34, 32'h0);
        ck({er, rd[30:0]}, 32'h8000_0000);
        $display("test regs done");
    endtask
    task t_addr;
        apb(1'b1, bbt_pkg::OFS_ADDR, 32'h1234);
        apb(1'b1, bbt_pkg::OFS_AMASK, 32'hF);
        ctl(cf(2'h1, 1'b1, 1'b1, 3'h7, 2'h0, 2'h0, 1'b0));
        go(24'h1234, 32'h0, 2'h0, 1'b0, 2'h0, 1'b1);
        go(24'h1235, 32'h0, 2'h0, 1'b1, 2'h1, 1'b0);
        go(24'h123A, 32'h0, 2'h0, 1'b0, 2'h0, 1'b0);
        ctl(cf(2'h1, 1'b1, 1'b1, 3'h7, 2'h0, 2'h0, 1'b1));
        go(24'h123A, 32'h0, 2'h0, 1'b0, 2'h0, 1'b1);
        go(24'h1334, 32'h0, 2'h0, 1'b0, 2'h0, 1'b0);
        ctl(cf(2'h1, 1'b1, 1'b1, 3'h7, 2'h1, 2'h0, 1'b0));
        go(24'h1234, 32'h0, 2'h0, 1'b1, 2'h0, 1'b0);
        ctl(cf(2'h0, 1'b1, 1'b1, 3'h7, 2'h0, 2'h0, 1'b0));
        go(24'h5678, 32'h0, 2'h2, 1'b1, 2'h2, 1'b1);
        $display("test address done");
    endtask
    task t_data;
        apb(1'b1, bbt_pkg::OFS_DATA, 32'hA5);
        apb(1'b1, bbt_pkg::OFS_DMASK, 32'hF);
        for (int s = 0; s < 3; s++) begin
            ctl(cf(2'h0, 1'b0, 1'b1, 3'h7, 2'h0, 2'(s), 1'b0));
            go(24'h1, 32'hA5, 2'(s), 1'b0, 2'h0, 1'b1);
            go(24'h1, 32'hA5, 2'((s + 1) % 3), 1'b0, 2'h0, 1'b0);
            go(24'h1, 32'hA4, 2'(s), 1'b0, 2'h0, 1'b0);
        end
        ctl(cf(2'h0, 1'b0, 1'b1, 3'h7, 2'h0, 2'h0, 1'b1));
        go(24'h1, 32'hAA, 2'h0, 1'b0, 2'h0, 1'b1);
        go(24'h1, 32'hB5, 2'h0, 1'b0, 2'h0, 1'b0);
        ctl(cf(2'h0, 1'b1, 1'b1, 3'h7, 2'h0, 2'h0, 1'b0));
        go(24'h1, 32'h55, 2'h2, 1'b0, 2'h0, 1'b1);
        $display("test data done");
    endtask
    task t_state;
        for (int m = 0; m < 3; m++) begin
            ctl(cf(2'h0, 1'b1, 1'b1, 3'(1 << m), 2'h0, 2'h0, 1'b0));
            go(24'h2, 32'h0, 2'h0, 1'b0, 2'(m), 1'b1);
            go(24'h2, 32'h0, 2'h0, 1'b0, 2'((m + 1) % 3), 1'b0);
        end
        for (int d = 1; d < 3; d++) begin
            ctl(cf(2'h0, 1'b1, 1'b1, 3'h7, 2'(d), 2'h0, 1'b0));
            go(24'h2, 32'h0, 2'h0, d == 2, 2'h0, 1'b1);
            go(24'h2, 32'h0, 2'h0, d != 2, 2'h0, 1'b0);
        end
        $display("test state done");
    endtask
    task t_count;
        apb(1'b1, bbt_pkg::OFS_COUNT, 32'h3);
        ctl(cf(2'h0, 1'b1, 1'b0, 3'h7, 2'h0, 2'h0, 1'b0));
        go(24'h3, 32'h0, 2'h0, 1'b0, 2'h0, 1'b0);
        go(24'h3, 32'h0, 2'h0, 1'b1, 2'h1, 1'b0);
        go(24'h3, 32'h0, 2'h0, 1'b0, 2'h2, 1'b1);
        go(24'h3, 32'h0, 2'h0, 1'b0, 2'h0, 1'b0);
        ctl(cf(2'h0, 1'b1, 1'b1, 3'h7, 2'h0, 2'h0, 1'b0));
        go(24'h3, 32'h0, 2'h0, 1'b0, 2'h0, 1'b1);
        $display("test count done");
    endtask
    task t_pref;
        ctl(cf(2'h2, 1'b0, 1'b1, 3'h0, 2'h1, 2'h0, 1'b0));
        i_bus.cyc(24'h1234, 32'h0, 2'h2, 1'b1, 2'h3, 1'b1);
        chkbr(1'b0);
        i_bus.ins(1'b1, 24'h1234);
        chkbr(1'b1);
        ctl(cf(2'h3, 1'b0, 1'b1, 3'h0, 2'h1, 2'h0, 1'b0));
        i_bus.cyc(24'h1234, 32'h0, 2'h2, 1'b1, 2'h3, 1'b1);
        i_bus.ins(1'b1, 24'h1234);
        chkbr(1'b0);
        i_bus.ins(1'b0, 24'h1234);
        chkbr(1'b1);
        $display("test prefetch done");
    endtask
    task t_irq;
        ctl(cf(2'h0, 1'b1, 1'b1, 3'h7, 2'h0, 2'h0, 1'b0));
        apb(1'b1, bbt_pkg::OFS_CLEAR, 32'h3);
        apb(1'b1, bbt_pkg::OFS_IRQEN, 32'h1);
        go(24'h4, 32'h0, 2'h0, 1'b0, 2'h0, 1'b1);
        @(posedge pclk);
        ck(32'(irq), 32'h1);
        apb(1'b0, bbt_pkg::OFS_STATUS, 32'h0);
        ck(rd & 32'h1, 32'h1);
        apb(1'b1, bbt_pkg::OFS_CLEAR, 32'h1);
        repeat (2) @(posedge pclk);
        ck(32'(irq), 32'h0);
        apb(1'b1, bbt_pkg::OFS_IRQEN, 32'h0);
        go(24'h4, 32'h0, 2'h0, 1'b0, 2'h0, 1'b1);
        repeat (2) @(posedge pclk);
        ck(32'(irq), 32'h0);
        $display("test interrupt done");
    endtask
    task trd(input logic [31:0] i, input logic [31:0] e);
        apb(1'b1, bbt_pkg::OFS_TIDX, i);
        apb(1'b0, bbt_pkg::OFS_TDATA, 32'h0);
        ck({7'h0, rd[31], rd[23:0]}, e);
    endtask
    task t_trace;
        // Ten entries into eight places: the two oldest drop out
        for (int i = 0; i < 5; i++)
            i_bus.br(24'h100 + 24'(i), 24'h200 + 24'(i));
        trd(32'h0, 32'h0100_0204);
        trd(32'h1, 32'h0000_0104);
        trd(32'h7, 32'h0000_0101);
        apb(1'b0, bbt_pkg::OFS_TINFO, 32'h0);
        ck(rd, 32'h8);
        $display("test trace done");
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_addr();
        t_data();
        t_state();
        t_count();
        t_pref();
        t_irq();
        t_trace();
        give_verdict();
    end
endmodule // tb_top
